// ===== pcr_pkg.sv
// Purpose: constants and types for the 40G PCS control/status register bank
// Assumes: APB slave, 32-bit data, registers in low 16 bits
// Notes: register index times four gives the byte address
package pcr_pkg;
	localparam logic [15:0] REG_CTRL_IDX   = 16'h3000;
	localparam logic [15:0] REG_STAT_IDX   = 16'h3001;
	localparam logic [15:0] REG_IRQ_ST_IDX = 16'h3100;
	localparam logic [15:0] REG_IRQ_MK_IDX = 16'h3101;
	localparam int          BIT_SRST       = 15;
	localparam int          BIT_LOOP       = 14;
	localparam int          BIT_SPD_HI     = 13;
	localparam int          BIT_LPWR       = 11;
	localparam int          BIT_CSTOP      = 10;
	localparam int          BIT_SPD_LO     = 6;
	localparam int          BIT_TX_LPI_L   = 11;
	localparam int          BIT_RX_LPI_L   = 10;
	localparam int          BIT_TX_LPI     = 9;
	localparam int          BIT_RX_LPI     = 8;
	localparam int          BIT_FAULT      = 7;
	localparam int          BIT_CSTOP_CAP  = 6;
	localparam int          BIT_LINK       = 2;
	localparam int          BIT_LP_ABLE    = 1;
	localparam logic [3:0]  SPEED_FIELD    = 4'h3;
	localparam logic [3:0]  IRQ_RST        = 4'h0;
	localparam logic [15:0] APB_SPACE_MSK  = 16'h3fff;

	typedef struct packed {
		logic tx_lpi;
		logic rx_lpi;
		logic fault;
		logic link;
	} pcr_cond_t;

	typedef struct packed {
		logic       loop;
		logic       lpwr;
		logic       cstop;
		logic       tx_lpi_l;
		logic       rx_lpi_l;
		logic       link_l;
		logic       srst;
		logic       strap_done;
		logic [3:0] irq_st;
		logic [3:0] irq_mk;
		logic [31:0] rdata;
		pcr_cond_t  cond;
	} pcr_state_t;
endpackage

// ===== pcr_regs.sv
// Purpose: 40G Pcs_control_one / status 1 registers behind an APB slave
// Assumes: condition inputs come from outside the clock domain
// Notes: zero-wait APB; unmapped addresses read zero with no error
module pcr_regs (
	input  wire logic        CLOCK,
	input  wire logic        RST_B,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [15:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        PORT0_40G_MODE,
	input  wire logic        LOW_POWER_STRAP,
	input  wire logic        TX_LPI_IN,
	input  wire logic        RX_LPI_IN,
	input  wire logic        FAULT_IN,
	input  wire logic        LINK_UP_IN,
	output logic             SOFT_RESET,
	output logic             LOOPBACK,
	output logic             LOW_POWER,
	output logic             CLOCK_STOP_OK,
	output logic             IRQ
);
	pcr_pkg::pcr_state_t s_q, s_d;
	pcr_pkg::pcr_cond_t  meta_q;
	logic                active;
	logic                wr;
	logic                rd;
	logic [13:0]         idx;
	logic [15:0]         ctrl_v;
	logic [15:0]         stat_v;
	logic [3:0]          ev;

	// first stage read only by the second (s_q.cond)
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			meta_q <= '0;
		end else begin
			meta_q <= '{TX_LPI_IN, RX_LPI_IN, FAULT_IN, LINK_UP_IN};
		end
	end

	assign active = PORT0_40G_MODE;
	assign idx    = PADDR[15:2] & pcr_pkg::APB_SPACE_MSK[13:0];
	assign wr     = PSEL && PENABLE && PWRITE && active;
	assign rd     = PSEL && PENABLE && !PWRITE && active;

	always_comb begin
		ctrl_v = '0;
		ctrl_v[pcr_pkg::BIT_SRST]   = s_q.srst;
		ctrl_v[pcr_pkg::BIT_LOOP]   = s_q.loop;
		ctrl_v[pcr_pkg::BIT_SPD_HI] = 1'b1;
		ctrl_v[pcr_pkg::BIT_LPWR]   = s_q.lpwr;
		ctrl_v[pcr_pkg::BIT_CSTOP]  = s_q.cstop;
		ctrl_v[pcr_pkg::BIT_SPD_LO] = 1'b1;
		ctrl_v[5:2]                 = pcr_pkg::SPEED_FIELD;
		stat_v = '0;
		stat_v[pcr_pkg::BIT_TX_LPI_L]  = s_q.tx_lpi_l;
		stat_v[pcr_pkg::BIT_RX_LPI_L]  = s_q.rx_lpi_l;
		stat_v[pcr_pkg::BIT_TX_LPI]    = s_q.cond.tx_lpi;
		stat_v[pcr_pkg::BIT_RX_LPI]    = s_q.cond.rx_lpi;
		stat_v[pcr_pkg::BIT_FAULT]     = s_q.cond.fault;
		stat_v[pcr_pkg::BIT_CSTOP_CAP] = 1'b0;
		stat_v[pcr_pkg::BIT_LINK]      = s_q.link_l;
		stat_v[pcr_pkg::BIT_LP_ABLE]   = 1'b1;
	end

	// events: tx lpi, rx lpi, fault, link drop
	assign ev = {s_q.cond.tx_lpi, s_q.cond.rx_lpi, s_q.cond.fault,
		s_q.link_l && !s_q.cond.link};

	always_comb begin
		s_d            = s_q;
		s_d.cond       = meta_q;
		s_d.strap_done = 1'b1;
		// strap caught once, just after reset release
		if (!s_q.strap_done) begin
			s_d.lpwr = LOW_POWER_STRAP;
		end
		// latched bits: hold until read, then reload from the live state and latch again
		if (rd && idx == pcr_pkg::REG_STAT_IDX[13:0]) begin
			s_d.tx_lpi_l = s_q.cond.tx_lpi;
			s_d.rx_lpi_l = s_q.cond.rx_lpi;
			s_d.link_l   = s_q.cond.link;
		end
		// a new event in the read cycle still wins
		if (s_q.cond.tx_lpi) begin
			s_d.tx_lpi_l = 1'b1;
		end
		if (s_q.cond.rx_lpi) begin
			s_d.rx_lpi_l = 1'b1;
		end
		if (!s_q.cond.link) begin
			s_d.link_l = 1'b0;
		end
		s_d.srst = 1'b0;
		if (wr && idx == pcr_pkg::REG_CTRL_IDX[13:0]) begin
			s_d.srst  = PWDATA[pcr_pkg::BIT_SRST];
			s_d.loop  = PWDATA[pcr_pkg::BIT_LOOP];
			s_d.lpwr  = PWDATA[pcr_pkg::BIT_LPWR];
			s_d.cstop = PWDATA[pcr_pkg::BIT_CSTOP];
		end
		if (wr && idx == pcr_pkg::REG_IRQ_MK_IDX[13:0]) begin
			s_d.irq_mk = PWDATA[3:0];
		end
		if (wr && idx == pcr_pkg::REG_IRQ_ST_IDX[13:0]) begin
			s_d.irq_st = s_q.irq_st & ~PWDATA[3:0];
		end
		s_d.irq_st = s_d.irq_st | ev;
		// soft reset pulse: loopback, clock stop and the latched status bits go back to reset value; low power and irq status/mask hold
		if (s_q.srst) begin
			s_d.loop     = 1'b0;
			s_d.cstop    = 1'b0;
			s_d.tx_lpi_l = 1'b0;
			s_d.rx_lpi_l = 1'b0;
			s_d.link_l   = 1'b0;
			s_d.lpwr     = s_q.lpwr;
		end
		s_d.rdata = '0;
		// a read setup while the port is off must not leave stale data up
		if (PSEL && !PENABLE && !PWRITE) begin
			if (active) begin
				unique case (idx)
					pcr_pkg::REG_CTRL_IDX[13:0]:   s_d.rdata = {16'h0000, ctrl_v};
					pcr_pkg::REG_STAT_IDX[13:0]:   s_d.rdata = {16'h0000, stat_v};
					pcr_pkg::REG_IRQ_ST_IDX[13:0]: s_d.rdata = {28'h000_0000, s_q.irq_st};
					pcr_pkg::REG_IRQ_MK_IDX[13:0]: s_d.rdata = {28'h000_0000, s_q.irq_mk};
					default:                       s_d.rdata = '0;
				endcase
			end else begin
				s_d.rdata = '0;
			end
		end else begin
			s_d.rdata = s_q.rdata;
		end
	end

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			s_q        <= '0;
			s_q.irq_st <= pcr_pkg::IRQ_RST;
			s_q.irq_mk <= pcr_pkg::IRQ_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign PRDATA        = s_q.rdata;
	assign PREADY        = 1'b1;
	assign PSLVERR       = 1'b0;
	assign SOFT_RESET    = s_q.srst;
	assign LOOPBACK      = s_q.loop;
	assign LOW_POWER     = s_q.lpwr;
	assign CLOCK_STOP_OK = s_q.cstop;
	assign IRQ           = |(s_q.irq_st & s_q.irq_mk);
endmodule

// ===== pcr_regs_checker.sv
// Purpose: port assertions for the PCS control/status bank
// Assumes: zero-wait APB, control at 16'hc000, status at 16'hc004
// Notes: soft reset clear may land one edge after the pulse
module pcr_regs_checker (
	input wire logic        CLOCK,
	input wire logic        RST_B,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [15:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	input wire logic        PORT0_40G_MODE,
	input wire logic        SOFT_RESET,
	input wire logic        LOOPBACK,
	input wire logic        LOW_POWER,
	input wire logic        CLOCK_STOP_OK,
	input wire logic        IRQ
);
	wire acc  = PSEL && PENABLE && PORT0_40G_MODE;
	wire wr_c = acc && PWRITE && PADDR == 16'hc000;
	wire rd_c = acc && !PWRITE && PADDR == 16'hc000;
	wire rd_s = acc && !PWRITE && PADDR == 16'hc004;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_B);
	a_srst_pulse:
		assert property (wr_c && PWDATA[15] |=> SOFT_RESET ##1 !SOFT_RESET) else $error("soft reset pulse");
	a_srst_clears:
		assert property (SOFT_RESET |=> !LOOPBACK && !CLOCK_STOP_OK && $stable(LOW_POWER)) else $error("soft reset");
	a_ctrl_write:
		assert property (wr_c && !PWDATA[15] && !SOFT_RESET |=> LOOPBACK == $past(PWDATA[14])
			&& LOW_POWER == $past(PWDATA[11])
			&& CLOCK_STOP_OK == $past(PWDATA[10])) else $error("control write");
	a_ctrl_fixed:
		assert property (rd_c |-> PRDATA[13] && PRDATA[6] && PRDATA[5:2] == 4'h3 && PRDATA[14] == LOOPBACK)
			else $error("control read");
	a_stat_fixed:
		assert property (rd_s |-> PRDATA[1] && !PRDATA[6] && PRDATA[31:12] == 20'h0_0000) else $error("status read");
	a_mode_read:
		assert property (!PORT0_40G_MODE && !$past(PORT0_40G_MODE) && PSEL && PENABLE && !PWRITE
			|-> PRDATA == 32'h0000_0000)
			else $error("read while off");
	a_mode_write:
		assert property (!PORT0_40G_MODE && PSEL && PENABLE |=> $stable(LOOPBACK)) else $error("write while off");
	a_zero_wait:
		assert property (PSEL && PENABLE |-> PREADY && !PSLVERR) else $error("wait state");
	cover property (wr_c && PWDATA[15]);
	cover property (rd_s && PRDATA[11]);
	cover property (IRQ);
endmodule
bind pcr_regs pcr_regs_checker chk_u (.*);

// ===== tb.sv
// Purpose: self-checking bench for the PCS control/status bank
// Assumes: zero-wait APB, one clock
// Notes: status inputs pass a two-flop synchroniser, so waits of six edges
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        CLOCK = 0, RST_B = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
	logic        PORT0_40G_MODE = 1, LOW_POWER_STRAP = 1, TX_LPI_IN = 0, RX_LPI_IN = 0, FAULT_IN = 0, LINK_UP_IN = 0;
	logic        PREADY, PSLVERR, SOFT_RESET, LOOPBACK, LOW_POWER, CLOCK_STOP_OK, IRQ;
	logic [15:0] PADDR = 16'h0000;
	logic [31:0] PWDATA = 32'h0000_0000, PRDATA, rd;
	int          errors = 0, n_compared = 0;
	pcr_regs dut_u (.*);
	initial forever #4 CLOCK = ~CLOCK;
	task automatic print_verdict;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			errors++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge CLOCK);
	endtask
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		int i;
		{PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, w, a, d};
		@(posedge CLOCK) PENABLE <= 1;
		for (i = 0; i < 20; i++) begin
			@(posedge CLOCK);
			if (PREADY === 1'b1) break;
		end
		if (i == 20) begin
			errors++;
			print_verdict;
		end
		rd = PRDATA;
		{PSEL, PENABLE} <= 2'b00;
		@(posedge CLOCK);
	endtask
	task automatic t_ctrl;
		apb(0, 16'hc000, 32'h0000_0000);
		chk("ctrl rst", rd, 32'h0000_284c);
		apb(1, 16'hc000, 32'h0000_7fff);
		apb(0, 16'hc000, 32'h0000_0000);
		chk("ctrl wr", rd, 32'h0000_6c4c);
		chk("outs", {LOOPBACK, CLOCK_STOP_OK, LOW_POWER}, 32'h0000_0007);
		apb(1, 16'hc000, 32'h0000_cc00);
		wt(2);
		apb(0, 16'hc000, 32'h0000_0000);
		chk("ctrl srst", rd, 32'h0000_284c);
		chk("outs srst", {LOOPBACK, CLOCK_STOP_OK, LOW_POWER}, 32'h0000_0001);
		$display("t_ctrl done");
	endtask
	task automatic t_stat;
		apb(0, 16'hc004, 32'h0000_0000);
		chk("st rst", rd, 32'h0000_0002);
		{TX_LPI_IN, RX_LPI_IN, FAULT_IN, LINK_UP_IN} <= 4'hf;
		wt(6);
		apb(0, 16'hc004, 32'h0000_0000);
		chk("st1", rd & 32'hffff_fffb, 32'h0000_0f82);
		apb(0, 16'hc004, 32'h0000_0000);
		chk("st2", rd, 32'h0000_0f86);
		{TX_LPI_IN, RX_LPI_IN, LINK_UP_IN} <= 3'h0;
		wt(6);
		apb(0, 16'hc004, 32'h0000_0000);
		chk("st3", rd, 32'h0000_0c82);
		apb(0, 16'hc004, 32'h0000_0000);
		chk("st4", rd, 32'h0000_0082);
		$display("t_stat done");
	endtask
	task automatic t_irq;
		apb(1, 16'hc404, 32'h0000_0002);
		apb(1, 16'hc400, 32'h0000_000f);
		apb(0, 16'hc400, 32'h0000_0000);
		chk("irq st", rd, 32'h0000_0002);
		chk("irq on", IRQ, 32'h0000_0001);
		apb(1, 16'hc404, 32'h0000_0000);
		wt(2);
		chk("irq off", IRQ, 32'h0000_0000);
		FAULT_IN <= 0;
		wt(6);
		apb(1, 16'hc400, 32'h0000_000f);
		apb(0, 16'hc400, 32'h0000_0000);
		chk("irq clr", rd, 32'h0000_0000);
		apb(0, 16'hc008, 32'h0000_0000);
		chk("unmapped", rd, 32'h0000_0000);
		$display("t_irq done");
	endtask
	task automatic t_mode;
		PORT0_40G_MODE <= 0;
		apb(1, 16'hc000, 32'h0000_4000);
		apb(0, 16'hc000, 32'h0000_0000);
		chk("off rd", rd, 32'h0000_0000);
		PORT0_40G_MODE <= 1;
		apb(0, 16'hc000, 32'h0000_0000);
		chk("on rd", rd, 32'h0000_284c);
		$display("t_mode done");
	endtask
	initial begin
		repeat (10) @(posedge CLOCK);
		RST_B <= 1;
		@(posedge CLOCK);
		t_ctrl;
		t_stat;
		t_irq;
		t_mode;
		print_verdict;
	end
endmodule
